// ===== hw/prog_entry_pkg.sv
package prog_entry_pkg;
	// ----------------------------------------
	// key and sizes
	// ----------------------------------------
	localparam int KEY_BITS = 32;
	localparam logic [31:0] KEY_DEFAULT = 32'h5a3c_96e1; // arbitrary value
	localparam logic [5:0] KEY_CNT_RESET = 6'h00;
	localparam logic [5:0] KEY_CNT_FULL = 6'h20;
	localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
	localparam logic [2:0] SYNC_RESET = 3'h0;

	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_KEY = 4'b0010,
		ST_HV = 4'b0100,
		ST_LV = 4'b1000
	} mode_e;
endpackage : prog_entry_pkg

// ===== hw/prog_mode_entry.sv
`timescale 1ns/1ns
module prog_mode_entry import prog_entry_pkg::*; #(
	parameter logic [31:0] KEY_VALUE = KEY_DEFAULT
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic progSerialClock,
	input wire logic progSerialDataIn,
	output logic progSerialDataOut,
	output logic progSerialDataOe_n,
	input wire logic masterClearLow,
	input wire logic highEntryVoltage,
	input wire logic lowVoltageProgEnable,
	input wire logic resetPinCfg,
	input wire logic readDataBit,
	input wire logic readDataDrive,
	input wire logic memWriteReq,
	input wire logic enClearReq,
	output logic progMode,
	output logic memWriteAllow,
	output logic enClearAllow,
	output logic resetPinEnable
);
	// ----------------------------------------
	// link domain: key shift on serial clock
	// ----------------------------------------
	logic lnkRst_n;
	logic [2:0] lnkClr_ff, nxt_lnkClr;
	logic [31:0] shift_ff, nxt_shift;
	logic [5:0] cnt_ff, nxt_cnt;
	logic keyOk_ff, nxt_keyOk;

	// serial clock idles between sessions: release of master clear drops a stale key result
	assign lnkRst_n = arst_n && masterClearLow;

	always_comb begin
		nxt_lnkClr = {lnkClr_ff[1:0], masterClearLow};
		nxt_shift = {shift_ff[30:0], progSerialDataIn};
		nxt_cnt = cnt_ff;
		nxt_keyOk = keyOk_ff;
		if (!lnkClr_ff[1]) begin
			nxt_cnt = KEY_CNT_RESET;
			nxt_keyOk = 1'b0;
		end else if (cnt_ff != KEY_CNT_FULL) begin
			nxt_cnt = cnt_ff + 6'h01;
			if (cnt_ff == KEY_CNT_FULL - 6'h01) begin
				nxt_keyOk = (nxt_shift == KEY_VALUE);
			end
		end
	end

	always_ff @(posedge progSerialClock or negedge lnkRst_n) begin
		if (!lnkRst_n) begin
			lnkClr_ff <= SYNC_RESET;
			shift_ff <= SHIFT_RESET;
			cnt_ff <= KEY_CNT_RESET;
			keyOk_ff <= 1'b0;
		end else begin
			lnkClr_ff <= nxt_lnkClr;
			shift_ff <= nxt_shift;
			cnt_ff <= nxt_cnt;
			keyOk_ff <= nxt_keyOk;
		end
	end

	// ----------------------------------------
	// link-side checks
	// ----------------------------------------
	a_key_count_cap: assert property (@(posedge progSerialClock) disable iff (!lnkRst_n)
		cnt_ff <= KEY_CNT_FULL)
		else $error("key bit count past full");

	a_key_ok_full: assert property (@(posedge progSerialClock) disable iff (!lnkRst_n)
		keyOk_ff |-> cnt_ff == KEY_CNT_FULL)
		else $error("key match flagged before all bits");

	// ----------------------------------------
	// input synchronisers into mclk
	// ----------------------------------------
	logic [1:0] sClr_ff, sHv_ff, sClk_ff, sDat_ff, sKey_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sClr_ff <= 2'h0;
			sHv_ff <= 2'h0;
			sClk_ff <= 2'h0;
			sDat_ff <= 2'h0;
			sKey_ff <= 2'h0;
		end else begin
			sClr_ff <= {sClr_ff[0], masterClearLow};
			sHv_ff <= {sHv_ff[0], highEntryVoltage};
			sClk_ff <= {sClk_ff[0], progSerialClock};
			sDat_ff <= {sDat_ff[0], progSerialDataIn};
			sKey_ff <= {sKey_ff[0], keyOk_ff};
		end
	end

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	mode_e mode_ff, nxt_mode;
	logic pinsLow;
	logic progMode_ff, nxt_progMode;
	logic memWr_ff, nxt_memWr;
	logic enClr_ff, nxt_enClr;
	logic rstPinEn_ff, nxt_rstPinEn;
	logic dOut_ff, nxt_dOut;
	logic dOe_ff, nxt_dOe;

	assign pinsLow = !sClk_ff[1] && !sDat_ff[1];

	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			ST_RUN: begin
				if (sHv_ff[1] && pinsLow) begin
					nxt_mode = ST_HV;
				end else if (sClr_ff[1] && lowVoltageProgEnable) begin
					nxt_mode = ST_KEY;
				end
			end
			ST_KEY: begin
				if (sHv_ff[1] && pinsLow) begin
					nxt_mode = ST_HV;
				end else if (!sClr_ff[1] || !lowVoltageProgEnable) begin
					nxt_mode = ST_RUN;
				end else if (sKey_ff[1]) begin
					nxt_mode = ST_LV;
				end
			end
			ST_HV: begin
				if (!sHv_ff[1]) begin
					nxt_mode = ST_RUN;
				end
			end
			ST_LV: begin
				if (!sClr_ff[1]) begin
					nxt_mode = ST_RUN;
				end
			end
			default: nxt_mode = ST_RUN;
		endcase
		nxt_progMode = (nxt_mode == ST_HV) || (nxt_mode == ST_LV);
		nxt_memWr = nxt_progMode && memWriteReq;
		nxt_enClr = (nxt_mode == ST_HV) && enClearReq;
		nxt_rstPinEn = lowVoltageProgEnable || resetPinCfg;
		nxt_dOut = readDataBit;
		nxt_dOe = !(nxt_progMode && readDataDrive);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= ST_RUN;
			progMode_ff <= 1'b0;
			memWr_ff <= 1'b0;
			enClr_ff <= 1'b0;
			rstPinEn_ff <= 1'b1;
			dOut_ff <= 1'b0;
			dOe_ff <= 1'b1;
		end else begin
			mode_ff <= nxt_mode;
			progMode_ff <= nxt_progMode;
			memWr_ff <= nxt_memWr;
			enClr_ff <= nxt_enClr;
			rstPinEn_ff <= nxt_rstPinEn;
			dOut_ff <= nxt_dOut;
			dOe_ff <= nxt_dOe;
		end
	end

	assign progMode = progMode_ff;
	assign memWriteAllow = memWr_ff;
	assign enClearAllow = enClr_ff;
	assign resetPinEnable = rstPinEn_ff;
	assign progSerialDataOut = dOut_ff;
	assign progSerialDataOe_n = dOe_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_lv_needs_key: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_KEY) && (nxt_mode == ST_LV) |-> sKey_ff[1])
		else $error("low-voltage mode without key match");

	a_lv_needs_enable: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_RUN) && !lowVoltageProgEnable && !sHv_ff[1] |=> mode_ff == ST_RUN)
		else $error("key entry with low-voltage disabled");

	a_lv_exit_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_LV) && !sClr_ff[1] |=> !progMode_ff)
		else $error("low-voltage mode held after master clear high");

	a_hv_entry: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_RUN) && sHv_ff[1] && pinsLow |=> progMode_ff && mode_ff == ST_HV)
		else $error("high-voltage entry missed");

	a_reset_forced: assert property (@(posedge mclk) disable iff (!arst_n)
		lowVoltageProgEnable |=> resetPinEnable)
		else $error("master clear reset not forced");

	a_en_clear_hv: assert property (@(posedge mclk) disable iff (!arst_n)
		enClearAllow |-> $past(nxt_mode) == ST_HV)
		else $error("enable clear outside high-voltage session");

	a_write_gate: assert property (@(posedge mclk) disable iff (!arst_n)
		memWriteAllow |-> progMode_ff)
		else $error("memory write outside program mode");

	a_data_drive: assert property (@(posedge mclk) disable iff (!arst_n)
		!progSerialDataOe_n |-> progMode_ff)
		else $error("data pin driven outside program mode");

	// ----------------------------------------
	// mode and output checks
	// ----------------------------------------
	a_mode_onehot: assert property (@(posedge mclk) disable iff (!arst_n)
		$onehot(mode_ff))
		else $error("mode register not one-hot");

	a_prog_mode_match: assert property (@(posedge mclk) disable iff (!arst_n)
		progMode_ff == ((mode_ff == ST_HV) || (mode_ff == ST_LV)))
		else $error("program mode flag disagrees with state");

	a_hv_exit: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_HV) && !sHv_ff[1] |=> !progMode_ff)
		else $error("high-voltage mode held after entry level gone");

	a_hv_stays: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_HV) && sHv_ff[1] |=> mode_ff == ST_HV)
		else $error("high-voltage mode lost while level held");

	a_hv_needs_pins: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_HV) && ($past(mode_ff) != ST_HV) |-> $past(sHv_ff[1] && pinsLow))
		else $error("high-voltage entry without pins low");

	a_hv_no_pins: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_RUN) && sHv_ff[1] && !pinsLow && !lowVoltageProgEnable
		|=> mode_ff == ST_RUN)
		else $error("high-voltage entry while pins not low");

	a_key_exit_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_KEY) && !sClr_ff[1] && !(sHv_ff[1] && pinsLow) |=> mode_ff == ST_RUN)
		else $error("key state held after master clear high");

	a_key_enable_drop: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_KEY) && !lowVoltageProgEnable && !(sHv_ff[1] && pinsLow)
		|=> mode_ff == ST_RUN)
		else $error("key state held with low-voltage disabled");

	a_lv_from_key: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_LV) && ($past(mode_ff) != ST_LV) |-> $past(mode_ff) == ST_KEY)
		else $error("low-voltage mode entered outside key state");

	a_lv_key_seen: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_LV) && ($past(mode_ff) != ST_LV) |-> $past(sKey_ff[1]))
		else $error("low-voltage mode entered without synced key match");

	a_lv_stays: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_LV) && sClr_ff[1] |=> mode_ff == ST_LV)
		else $error("low-voltage mode lost while master clear low");

	a_write_needs_req: assert property (@(posedge mclk) disable iff (!arst_n)
		memWriteAllow |-> $past(memWriteReq))
		else $error("memory write granted without request");

	a_write_granted: assert property (@(posedge mclk) disable iff (!arst_n)
		nxt_progMode && memWriteReq |=> memWriteAllow)
		else $error("memory write refused in program mode");

	a_clear_not_lv: assert property (@(posedge mclk) disable iff (!arst_n)
		(mode_ff == ST_LV) |=> !enClearAllow)
		else $error("enable clear granted from low-voltage session");

	a_clear_needs_req: assert property (@(posedge mclk) disable iff (!arst_n)
		enClearAllow |-> $past(enClearReq))
		else $error("enable clear granted without request");

	a_reset_released: assert property (@(posedge mclk) disable iff (!arst_n)
		!(lowVoltageProgEnable || resetPinCfg) |=> !resetPinEnable)
		else $error("master clear reset on with both sources off");

	a_dout_follow: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> progSerialDataOut == $past(readDataBit))
		else $error("data pin value not following core bit");

	a_drive_needs_req: assert property (@(posedge mclk) disable iff (!arst_n)
		!progSerialDataOe_n |-> $past(readDataDrive))
		else $error("data pin driven without drive request");
endmodule : prog_mode_entry

// ===== sim/prog_model.sv
`timescale 1ns/1ns
module prog_model (
	output logic sck,
	output logic sdat
);
	initial begin
		sck = 1'b0;
		sdat = 1'b0;
	end
	// both pins low before the high entry level
	task automatic hold_low();
		sck = 1'b0;
		sdat = 1'b0;
	endtask : hold_low
	// two dummy clocks, then the key msb first
	task automatic send_key(input logic [31:0] k);
		logic [33:0] s;
		s = {2'b00, k};
		#2;
		for (int i = 33; i >= 0; i--) begin
			sdat = s[i];
			#3 sck = 1'b1;
			#3 sck = 1'b0;
		end
		sdat = ~s[0];
	endtask : send_key
endmodule : prog_model

// ===== sim/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench import prog_entry_pkg::*;;
	logic mclk = 1'b0, arst_n = 1'b0, sck, sdat, dOut, dOe_n, mode, wrOk, clrOk, mre;
	logic [7:0] in = 8'h00;
	logic [5:0] q[$];
	logic [5:0] ev;
	logic [31:0] k;
	logic r, m;
	int err_total = 0, tests_run = 0;
	event chk;
	wire [5:0] obs = {mode, wrOk, clrOk, mre, dOe_n, dOut};
	always #25 mclk = ~mclk;
	prog_model pm (.sck(sck), .sdat(sdat));
	prog_mode_entry dut (.mclk(mclk), .arst_n(arst_n), .progSerialClock(sck),
		.progSerialDataIn(sdat), .progSerialDataOut(dOut), .progSerialDataOe_n(dOe_n),
		.masterClearLow(in[7]), .highEntryVoltage(in[6]), .lowVoltageProgEnable(in[5]),
		.resetPinCfg(in[4]), .readDataBit(in[3]), .readDataDrive(in[2]),
		.memWriteReq(in[1]), .enClearReq(in[0]), .progMode(mode),
		.memWriteAllow(wrOk), .enClearAllow(clrOk), .resetPinEnable(mre));
	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
	endtask : wait_n
	task automatic drv(input logic [7:0] v, input int n);
		@(posedge mclk);
		in <= v;
		wait_n(n);
	endtask : drv
	task automatic note(input logic [5:0] e);
		q.push_back(e);
		->chk;
	endtask : note
	always @(chk) begin
		@(negedge mclk);
		ev = q.pop_front();
		`CHK(obs, ev)
	end
	task automatic summarize();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		#400000;
		err_total++;
		summarize();
	end
	initial begin
		void'($urandom(32'h585dd499));
		wait_n(3);
		arst_n <= 1'b1;
		drv(8'h20, 3);
		note(6'b000110);
		pm.hold_low();
		r = $urandom % 2;
		drv({4'b0110, r, 3'b111}, 8);
		note({5'b11110, r});
		drv(8'h23, 8);
		note(6'b000110);
		$display("high voltage test done");
		for (int i = 0; i < 3; i++) begin
			k = (i == 1) ? (KEY_DEFAULT ^ ({$urandom} | 32'h1)) : KEY_DEFAULT;
			m = (i == 0);
			drv({1'b1, 1'b0, i != 2, 5'b00011}, 4);
			pm.send_key(k);
			wait_n(12);
			note({m, m, 1'b0, i != 2, 2'b10});
			drv({2'b00, i != 2, 5'b00011}, 8);
			note({3'b000, i != 2, 2'b10});
			$display("low voltage test %0d done", i);
		end
		wait_n(2);
		summarize();
	end
endmodule : testbench
